/* cfb_pkg.sv */
/*
 cfb_pkg: constants and carrier types for the cpu interrupt flag bank.
 assumes: 32-bit apb, register index times four gives the byte address.
*/
package cfb_pkg;

   // apb address width in bits
   localparam int unsigned CFB_AW = 12;

   // register indices; byte address is index times four
   localparam logic [9:0] CFB_IDX_RADIO  = 10'h09b;
   localparam logic [9:0] CFB_IDX_TDP    = 10'h0c0;
   localparam logic [9:0] CFB_IDX_STATUS = 10'h100;
   localparam logic [9:0] CFB_IDX_MASK   = 10'h101;

   // values after reset
   localparam logic [7:0] CFB_RADIO_RST  = 8'h00;
   localparam logic [7:0] CFB_TDP_RST    = 8'h00;
   localparam logic [7:0] CFB_STATUS_RST = 8'h00;
   localparam logic [7:0] CFB_MASK_RST   = 8'h00;

   // writable bits of the radio flag register (upper bits unused)
   localparam logic [7:0] CFB_RADIO_WMASK = 8'h03;

   // field positions in the timer/dma/port flag register
   localparam int unsigned CFB_DMA_BIT   = 0;
   localparam int unsigned CFB_T1_BIT    = 1;
   localparam int unsigned CFB_P0_BIT    = 5;
   localparam int unsigned CFB_RSV_BIT   = 6;
   localparam int unsigned CFB_SLEEP_BIT = 7;

   // mask of the four timer flags, bits 4..1
   localparam logic [7:0] CFB_TIMER_MASK = 8'h1e;

   // field positions in the sticky event status and mask registers
   localparam int unsigned CFB_EV_RADIO = 0;
   localparam int unsigned CFB_EV_DMA   = 1;
   localparam int unsigned CFB_EV_T1    = 2;
   localparam int unsigned CFB_EV_P0    = 6;
   localparam int unsigned CFB_EV_SLEEP = 7;

   // peripheral event pulses, one clock wide
   typedef struct packed {
      logic       sleep_tick;    // sleep timer event
      logic       port_zero;     // port 0 event
      logic [3:0] timer;         // bit 0 is timer 1
      logic       transfer_done; // dma completion
      logic       radio_general; // radio general interrupt
   } cfb_evt_s;

endpackage : cfb_pkg

/* cfb_flag_bank.sv */
/*
 cfb_flag_bank: two cpu interrupt flag registers behind an apb slave,
 with a sticky event status, a mask and one interrupt output.
 assumes: event pulses and vector acknowledges come from logic on pclk,
 so they are not synchronised; the apb master follows apb4 signalling.
*/
// Functional notes
// - radio event sets both radio flag bits
// - either radio bit alone raises a request
// - flag bits read one when pending
// - timer flags set on event, cleared on vectoring
// - sleep bit7, port0 bit5, dma bit0
// - radio bits 7:2 unused, read zero
`timescale 1ns/1ps
module cfb_flag_bank
   import cfb_pkg::*;
(
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [CFB_AW-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // peripheral events and core vectoring
   input  wire cfb_evt_s          evt,
   input  wire logic [3:0]        vec_timer_ack,
   // flags and requests toward the core
   output logic      [7:0]        radio_flags,
   output logic      [7:0]        tdp_flags,
   output logic                   radio_req,
   output logic                   tdp_req,
   output logic                   irq
);

   // true when the byte address selects the given register index
   function automatic logic hit(input logic [CFB_AW-1:0] a,
                                input logic [9:0] idx);
      hit = (a[CFB_AW-1:2] == idx) && (a[1:0] == 2'b00);
   endfunction : hit

   // registers and their next values
   logic [7:0]  radio_r, radio_nxt;       // radio flag register
   logic [7:0]  tdp_r, tdp_nxt;           // timer/dma/port flags
   logic        rreq_r, rreq_nxt;         // radio request
   logic        treq_r, treq_nxt;         // timer/dma/port request
   logic [7:0]  stat_r, stat_nxt;         // sticky event status
   logic [7:0]  mask_r, mask_nxt;         // event mask
   logic        irq_r, irq_nxt;           // interrupt output
   logic [31:0] prdata_r, prdata_nxt;     // read data
   logic        pready_r, pready_nxt;     // access-phase ready
   logic        pslverr_r, pslverr_nxt;   // unmapped address

   // decoded bus terms
   logic        setup;      // first cycle of a transfer
   logic        access;     // completing edge of a transfer
   logic        wr_ok;      // write that lands in the low byte
   logic        wr_radio;   // write to the radio flags
   logic        wr_tdp;     // write to the timer/dma/port flags
   logic        wr_stat;    // write-one-to-clear of the status
   logic        wr_mask;    // write to the mask
   logic        mapped;     // address decodes to a register
   logic [7:0]  evt_vec;    // events laid out as status bits

   // bus phase decode; writes act only on the completing edge
   always_comb begin
      setup    = psel && !penable;
      access   = psel && penable && pready_r;
      // lane 0 carries all eight bits, so a write without it is dropped
      wr_ok    = access && pwrite && pstrb[0];
      wr_radio = wr_ok && hit(paddr, CFB_IDX_RADIO);
      wr_tdp   = wr_ok && hit(paddr, CFB_IDX_TDP);
      wr_stat  = wr_ok && hit(paddr, CFB_IDX_STATUS);
      wr_mask  = wr_ok && hit(paddr, CFB_IDX_MASK);
      mapped   = hit(paddr, CFB_IDX_RADIO) || hit(paddr, CFB_IDX_TDP)
              || hit(paddr, CFB_IDX_STATUS) || hit(paddr, CFB_IDX_MASK);
   end

   // event pulses gathered into the status layout
   always_comb begin
      evt_vec                      = 8'h00;
      evt_vec[CFB_EV_RADIO]        = evt.radio_general;
      evt_vec[CFB_EV_DMA]          = evt.transfer_done;
      evt_vec[CFB_EV_T1 +: 4]      = evt.timer;
      evt_vec[CFB_EV_P0]           = evt.port_zero;
      evt_vec[CFB_EV_SLEEP]        = evt.sleep_tick;
   end

   // next flag values: software write first, then hardware clear,
   // hardware set last so an event in the clearing cycle is kept
   always_comb begin
      radio_nxt = radio_r;
      tdp_nxt   = tdp_r;
      if (wr_radio) begin
         // only bits 1:0 are stored, the rest stay zero
         radio_nxt = pwdata[7:0] & CFB_RADIO_WMASK;
      end
      if (evt.radio_general) begin
         // the radio always sets the pair together
         radio_nxt[1:0] = 2'b11;
      end
      if (wr_tdp) begin
         // every bit writable; reserved bit 6 is left to software
         tdp_nxt = pwdata[7:0];
      end
      // vectoring clears only the timer flags
      tdp_nxt[CFB_T1_BIT +: 4] = tdp_nxt[CFB_T1_BIT +: 4] & ~vec_timer_ack;
      // timer events set bits 4..1
      tdp_nxt[CFB_T1_BIT +: 4] = tdp_nxt[CFB_T1_BIT +: 4] | evt.timer;
      // fixed positions of the remaining sources
      if (evt.sleep_tick) begin
         tdp_nxt[CFB_SLEEP_BIT] = 1'b1;
      end
      if (evt.port_zero) begin
         tdp_nxt[CFB_P0_BIT] = 1'b1;
      end
      if (evt.transfer_done) begin
         tdp_nxt[CFB_DMA_BIT] = 1'b1;
      end
      // one radio bit alone is enough to request service
      rreq_nxt = |radio_nxt[1:0];
      // a stuck reserved bit keeps the request up, hence re-entry
      treq_nxt = |tdp_nxt;
   end

   // flag registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         radio_r <= CFB_RADIO_RST;
         tdp_r   <= CFB_TDP_RST;
         rreq_r  <= 1'b0;
         treq_r  <= 1'b0;
      end else begin
         radio_r <= radio_nxt;
         tdp_r   <= tdp_nxt;
         rreq_r  <= rreq_nxt;
         treq_r  <= treq_nxt;
      end
   end

   // sticky status and mask; a set in the clearing cycle wins
   always_comb begin
      stat_nxt = stat_r;
      mask_nxt = mask_r;
      if (wr_stat) begin
         stat_nxt = stat_r & ~pwdata[7:0];
      end
      stat_nxt = stat_nxt | evt_vec;
      if (wr_mask) begin
         mask_nxt = pwdata[7:0];
      end
      irq_nxt = |(stat_nxt & mask_nxt);
   end

   // status, mask and interrupt registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_r <= CFB_STATUS_RST;
         mask_r <= CFB_MASK_RST;
         irq_r  <= 1'b0;
      end else begin
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         irq_r  <= irq_nxt;
      end
   end

   // bus answer prepared in the setup cycle, so every access has
   // exactly one access cycle and outputs still come from flops
   always_comb begin
      prdata_nxt  = 32'h0000_0000;
      pready_nxt  = setup;
      pslverr_nxt = setup && !mapped;
      if (setup && !pwrite) begin
         // flags read back as held: one is pending
         if (hit(paddr, CFB_IDX_RADIO)) begin
            prdata_nxt[7:0] = radio_r;
         end else if (hit(paddr, CFB_IDX_TDP)) begin
            prdata_nxt[7:0] = tdp_r;
         end else if (hit(paddr, CFB_IDX_STATUS)) begin
            prdata_nxt[7:0] = stat_r;
         end else if (hit(paddr, CFB_IDX_MASK)) begin
            prdata_nxt[7:0] = mask_r;
         end
      end
   end

   // bus answer registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r  <= 32'h0000_0000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // outputs straight from flops
   assign prdata      = prdata_r;
   assign pready      = pready_r;
   assign pslverr     = pslverr_r;
   assign radio_flags = radio_r;
   assign tdp_flags   = tdp_r;
   assign radio_req   = rreq_r;
   assign tdp_req     = treq_r;
   assign irq         = irq_r;

   // checks on the flag behaviour
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // a radio event shows as both bits on the next cycle
   AST_RADIO_PAIR: assert property (
      evt.radio_general |=> radio_flags[1:0] == 2'b11)
      else $error("radio event did not set both flag bits");

   // a single radio bit written by software requests service
   AST_RADIO_ONE: assert property (
      wr_radio && pwdata[1:0] == 2'b01 && !evt.radio_general
      |=> radio_flags[1:0] == 2'b01 && radio_req)
      else $error("single radio bit gave no request");

   // a read returns the flag value seen at the setup cycle
   AST_READBACK: assert property (
      setup && !pwrite && hit(paddr, CFB_IDX_TDP)
      |=> prdata[7:0] == $past(tdp_r) && pready)
      else $error("flag readback mismatch");

   // timer 1 event sets its flag
   AST_TIMER_SET: assert property (
      evt.timer[0] |=> tdp_flags[CFB_T1_BIT])
      else $error("timer event did not set flag");

   // vectoring clears the timer 1 flag when no event competes
   AST_TIMER_CLR: assert property (
      vec_timer_ack[0] && !evt.timer[0] |=> !tdp_flags[CFB_T1_BIT])
      else $error("vectoring did not clear timer flag");

   // sleep, port 0 and dma sit at their fixed positions
   AST_FIXED_POS: assert property (
      evt.sleep_tick && evt.port_zero && evt.transfer_done
      |=> tdp_flags[CFB_SLEEP_BIT] && tdp_flags[CFB_P0_BIT]
          && tdp_flags[CFB_DMA_BIT])
      else $error("fixed flag position wrong");

   // unused radio bits never rise
   AST_UNUSED_ZERO: assert property (
      radio_flags[7:2] == 6'h00)
      else $error("unused radio bits set");

   // sleep flag survives vectoring until software writes it
   AST_SLEEP_HOLD: assert property (
      tdp_flags[CFB_SLEEP_BIT] && !wr_tdp && vec_timer_ack != 4'h0
      |=> tdp_flags[CFB_SLEEP_BIT])
      else $error("sleep flag lost without software write");

endmodule : cfb_flag_bank

/* cfb_core_vec_model.sv */
/*
 cfb_core_vec_model: stand-in for the core's vectoring, pulses one timer ack.
 assumes: requests come from the bench on pclk; one request at a time.
*/
`timescale 1ns/1ps
module cfb_core_vec_model (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // request from the bench: which timer routine, after how many cycles
   input  wire logic       go,
   input  wire logic [1:0] idx,
   input  wire logic [3:0] lat,
   // vectoring pulse toward the flag bank
   output logic      [3:0] vec_timer_ack
);
   logic [3:0] cnt_r; // cycles left before vectoring
   logic       pend_r; // a vector is waiting
   logic [1:0] idx_r; // routine to enter

   // latency lets the core answer promptly or slowly
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
         pend_r <= 1'b0;
         idx_r <= '0;
         vec_timer_ack <= '0;
      end else begin
         vec_timer_ack <= '0;
         if (go) begin
            cnt_r <= lat;
            idx_r <= idx;
            pend_r <= 1'b1;
         end else if (pend_r && cnt_r == 4'h0) begin
            vec_timer_ack <= 4'h1 << idx_r;
            pend_r <= 1'b0;
         end else if (pend_r) begin
            cnt_r <= cnt_r - 4'h1;
         end
      end
   end
endmodule : cfb_core_vec_model

/* tb_cpu_interrupt_flag_bank.sv */
/*
 tb_cpu_interrupt_flag_bank: model-checked bench for the flag bank.
 assumes: apb slave answers after one access cycle; events are 1-cycle pulses.
*/
`timescale 1ns/1ps
`define CK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_cpu_interrupt_flag_bank;
   import cfb_pkg::*;
   localparam logic [11:0] RA = {CFB_IDX_RADIO, 2'b00};
   localparam logic [11:0] TA = {CFB_IDX_TDP, 2'b00};
   localparam logic [11:0] SA = {CFB_IDX_STATUS, 2'b00};
   localparam logic [11:0] MA = {CFB_IDX_MASK, 2'b00};
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        radio_req, tdp_req, irq, v_go;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  radio_flags, tdp_flags, rf, tf, st, mk; // rf..mk: bench model
   logic [3:0]  vec_timer_ack, v_lat;
   logic [3:0]  pstrb, sb; // sb: byte lanes that the next transfer drives
   logic [1:0]  v_idx;
   cfb_evt_s    evt, e;
   int          miscompares, n_tests;

   cfb_flag_bank cfb_flag_bank_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .evt(evt), .vec_timer_ack(vec_timer_ack), .radio_flags(radio_flags),
      .tdp_flags(tdp_flags), .radio_req(radio_req), .tdp_req(tdp_req), .irq(irq));
   cfb_core_vec_model cfb_core_vec_model_inst (.pclk(pclk), .presetn(presetn), .go(v_go), .idx(v_idx),
      .lat(v_lat), .vec_timer_ack(vec_timer_ack));

   // free-running clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic summarize();
      if (miscompares == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize

   // compare flags, requests and irq against the model
   task automatic chk();
      `CK("radio_flags", rf, radio_flags)
      `CK("tdp_flags", tf, tdp_flags)
      `CK("radio_req", 1'(rf != 8'h00), radio_req)
      `CK("tdp_req", 1'(tf != 8'h00), tdp_req)
      `CK("irq", 1'((st & mk) != 8'h00), irq)
   endtask : chk

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      pstrb <= sb;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
      if (k >= 20) miscompares++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
      case (a)
         RA: rf = d & CFB_RADIO_WMASK;
         TA: tf = d;
         SA: st = st & ~d;
         MA: mk = d;
         default: ;
      endcase
      #1 chk();
      // the answer stands for the access cycle only
      `CK("pready", 1'b0, pready)
   endtask : wr

   task automatic rdchk(input logic [11:0] a, input logic [7:0] x, input logic er);
      apb(1'b0, a, 32'h0);
      `CK("prdata", ({24'h0, x}), rd)
      `CK("pslverr", er, err)
   endtask : rdchk

   // one-cycle event pulse, then the flags it must set
   task automatic ev(input cfb_evt_s x);
      @(posedge pclk); evt <= x;
      @(posedge pclk); evt <= '0;
      if (x.radio_general) rf = rf | 8'h03;
      tf = tf | {x.sleep_tick, 1'b0, x.port_zero, x.timer, x.transfer_done};
      st = st | x;
      #1 chk();
   endtask : ev

   // core vectors to timer i+1 routine after a random latency
   task automatic vec(input int i);
      int k;
      @(posedge pclk); v_go <= 1'b1; v_idx <= i[1:0]; v_lat <= 4'($urandom_range(0, 5));
      @(posedge pclk); v_go <= 1'b0;
      k = 0;
      while (vec_timer_ack === 4'h0 && k < 20) begin @(posedge pclk); k++; end
      if (k >= 20) miscompares++;
      tf[i+1] = 1'b0;
      #1 chk();
   endtask : vec

   initial begin
      #100000;
      miscompares++;
      summarize();
   end

   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
      evt = '0; v_go = 1'b0; v_idx = '0; v_lat = '0;
      pstrb = 4'hf;
      sb = 4'hf;
      rf = '0; tf = '0; st = '0; mk = '0; miscompares = 0; n_tests = 0;
      void'($urandom(32'h165a3803));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(RA, CFB_RADIO_RST, 1'b0);
      rdchk(TA, CFB_TDP_RST, 1'b0);
      rdchk(SA, 8'h00, 1'b0);
      rdchk(MA, 8'h00, 1'b0);
      wr(MA, 8'hff);
      e = '0; e.radio_general = 1'b1;
      ev(e);
      rdchk(RA, 8'h03, 1'b0);
      wr(SA, 8'h01);
      wr(RA, 8'h01);
      wr(RA, 8'h02);
      wr(RA, 8'h00);
      wr(RA, 8'hff);
      rdchk(RA, 8'h03, 1'b0);
      for (int i = 0; i < 4; i++) begin
         e = '0; e.timer[i] = 1'b1;
         ev(e);
         vec(i);
      end
      e = '0; e.sleep_tick = 1'b1; e.port_zero = 1'b1; e.transfer_done = 1'b1; e.timer = 4'hf;
      ev(e);
      for (int i = 0; i < 4; i++) vec(i);
      rdchk(TA, 8'ha1, 1'b0);
      rdchk(SA, st, 1'b0);
      wr(MA, 8'h00);
      wr(MA, 8'h80);
      wr(SA, 8'h80);
      repeat (6) wr(TA, 8'($urandom) & 8'hbf);
      rdchk(TA, tf, 1'b0);
      wr(TA, 8'h00);
      apb(1'b1, 12'h010, 32'h0000_00ff);
      `CK("pslverr", 1'b1, err)
      rdchk(12'h010, 8'h00, 1'b1);
      // a write without lane 0 must leave the mask as it was
      sb = 4'he;
      apb(1'b1, MA, 32'h0000_00ff);
      sb = 4'hf;
      #1 chk();
      rdchk(MA, mk, 1'b0);
      // reset in mid-run: flags, status and mask all return to zero
      @(posedge pclk);
      presetn <= 1'b0;
      rf = '0;
      tf = '0;
      st = '0;
      mk = '0;
      repeat (2) @(posedge pclk);
      #1 chk();
      @(posedge pclk);
      presetn <= 1'b1;
      rdchk(TA, CFB_TDP_RST, 1'b0);
      rdchk(MA, CFB_MASK_RST, 1'b0);
      summarize();
   end
endmodule : tb_cpu_interrupt_flag_bank
